// ===== freq_ctrl_cfg.svh
// constants for the frequency program / watchdog recovery block
// assumes a 125 MHz system clock and byte-wide register access
`ifndef FREQ_CTRL_CFG_SVH
`define FREQ_CTRL_CFG_SVH

// ==========================================
// register offsets (command code low bits)
`define OFS_WDOG_CTRL      7'h0e
`define OFS_WDOG_TIMER     7'h0f
`define OFS_SPARE_SIXTEEN  7'h10
`define OFS_SPARE_SEVNTEEN 7'h11
`define OFS_RECOV_NUM      7'h12
`define OFS_RECOV_DEN      7'h13
`define OFS_CPU_NUM        7'h14
`define OFS_CPU_DEN        7'h15
`define OFS_FACTORY_TEST   7'h16
`define OFS_FREQ_SELECT    7'h00

// ==========================================
// reset values
`define RST_FACTORY_TEST   8'h03
`define RST_WDOG_TIMER     5'h1f
`define RST_ZERO_BYTE      8'h00

// ==========================================
// field positions
`define BIT_TOP            7
`define BIT_OVERRIDE       3
`define BIT_RST_ON_TO      4
`define BIT_RST_ON_CHG     3
`define BIT_TO_FLAG        2
`define BIT_WATCHDOG_ENABLE          1
`define BIT_SCALE          5

// ==========================================
// timing
`define STEP_SHORT_MS      150
`define STEP_LONG_MS       2500
`define CLK_KHZ            125000
`define RESET_PULSE_CYC    8'h10

`endif

// ===== freq_ctrl_pkg.sv
// types for the frequency program / watchdog recovery block
// assumes the cfg header supplies the numeric constants
`default_nettype none
package freq_ctrl_pkg;
	// ==========================================
	// frequency source in effect
	typedef enum logic [1:0] {src_strap, src_soft, src_prog, src_recov} freq_src_e;
	// watchdog states
	typedef enum logic [1:0] {wd_idle, wd_armed, wd_count, wd_locked} wd_state_e;
	// frequency setting handed to the synthesizer
	typedef struct packed {
		logic [4:0] gear_code;
		logic [7:0] numerator;
		logic [6:0] denominator;
		logic       prog_mode;
	} freq_word_s;
	// register write strobe with data
	typedef struct packed {
		logic       we;
		logic [6:0] addr;
		logic [7:0] data;
	} reg_wr_s;
endpackage
`default_nettype wire

// ===== freq_ctrl.sv
// frequency selection, watchdog and recovery control
// assumes an smbus engine hands over byte writes and reads by offset,
// strap pins are stable during reset, and reset is synchronous
// ==========================================
// Overview of operation
// - recovery source: strap or recovery pair
// - recovery frequency from recovery num/den
// - non-prog mode: strap or soft code
// - prog mode: gear*(n+3)/(m+3)
// - gear and ratio from soft or strap
// - num or den write loads new frequency
// - enable cleared: stop, reload, unlock
// - enabled watchdog counts after frequency change
// - time-out: reset, recovery frequency, lock
// - locked: ignore frequency-changing writes
// - flag reads one after time-out; write-one clears
// - five-bit value, 150 ms or 2.5 s steps
// - count reaching zero sets flag
// - time-out reset only if enabled
// - change reset only if enabled
// - soft code uses gear 48.000741 table
`include "freq_ctrl_cfg.svh"
`default_nettype none
module freq_ctrl
	import freq_ctrl_pkg::*;
#(
	parameter int unsigned STEP_SHORT_CYC = `STEP_SHORT_MS * `CLK_KHZ,
	parameter int unsigned STEP_LONG_CYC  = `STEP_LONG_MS * `CLK_KHZ
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [3:0] strap_freq_code,
	input  wire reg_wr_s    reg_wr,
	input  wire logic [6:0] rd_addr,
	output var  logic [7:0] rd_data,
	output var  freq_word_s freq_word,
	output var  logic       freq_load,
	output var  logic       sys_reset_n_oe,
	output var  logic       recovery_active
);
	// ==========================================
	// registers
	logic [3:0] strap_reg;        // latched strap code
	logic       strap_taken_reg;  // strap caught after reset release
	logic [7:0] freq_sel_reg;     // override and soft code
	logic [7:0] wd_ctrl_reg;      // reset enables and watchdog enable
	logic       to_flag_reg;      // sticky time-out flag
	logic [4:0] wd_timeout_reg;   // time-out value
	logic       scale_reg;        // step select
	logic [7:0] recov_num_reg;    // recovery numerator
	logic [7:0] recov_den_reg;    // recovery source and denominator
	logic [7:0] cpu_num_reg;      // cpu numerator
	logic [7:0] cpu_den_reg;      // prog enable and cpu denominator
	logic [7:0] factory_reg;      // factory test byte
	wd_state_e  wd_state_reg;     // watchdog state
	logic [4:0] wd_count_reg;     // remaining steps
	logic [31:0] pre_count_reg;   // prescale counter
	logic [7:0] rst_pulse_reg;    // remaining reset pulse cycles
	logic       change_reg;       // frequency change one cycle late

	// ==========================================
	// write decode
	wire locked        = (wd_state_reg == wd_locked);
	wire wr_sel        = reg_wr.we && reg_wr.addr == `OFS_FREQ_SELECT;
	wire wr_wdc        = reg_wr.we && reg_wr.addr == `OFS_WDOG_CTRL;
	wire wr_wdt        = reg_wr.we && reg_wr.addr == `OFS_WDOG_TIMER;
	wire wr_rnum       = reg_wr.we && reg_wr.addr == `OFS_RECOV_NUM;
	wire wr_rden       = reg_wr.we && reg_wr.addr == `OFS_RECOV_DEN;
	wire wr_cnum       = reg_wr.we && reg_wr.addr == `OFS_CPU_NUM;
	wire wr_cden       = reg_wr.we && reg_wr.addr == `OFS_CPU_DEN;
	wire wr_fact       = reg_wr.we && reg_wr.addr == `OFS_FACTORY_TEST;
	// frequency-affecting writes are dropped while locked
	wire sel_ok        = wr_sel && !locked;
	wire cpu_pair_ok   = (wr_cnum || wr_cden) && !locked;
	wire rec_pair_ok   = (wr_rnum || wr_rden) && !locked;
	// values the registers take at this edge, so a load carries the new setting
	// rather than the one the write is replacing
	wire [7:0] sel_next       = sel_ok ? reg_wr.data : freq_sel_reg;
	wire [7:0] recov_num_next = (wr_rnum && !locked) ? reg_wr.data : recov_num_reg;
	wire [7:0] recov_den_next = (wr_rden && !locked) ? reg_wr.data : recov_den_reg;
	wire [7:0] cpu_num_next   = (wr_cnum && !locked) ? reg_wr.data : cpu_num_reg;
	wire [7:0] cpu_den_next   = (wr_cden && !locked) ? reg_wr.data : cpu_den_reg;
	// strap pins used directly until the latch has caught them
	wire [3:0] strap_now      = strap_taken_reg ? strap_reg : strap_freq_code;
	wire override      = sel_next[`BIT_OVERRIDE];
	// soft code bits are scattered in the select byte
	wire [4:0] soft_code = {sel_next[2:1], sel_next[6:4]};
	wire prog_en       = cpu_den_next[`BIT_TOP];
	wire recov_pair    = recov_den_next[`BIT_TOP];
	wire watchdog_enable         = wd_ctrl_reg[`BIT_WATCHDOG_ENABLE];
	wire watchdog_enable_clear   = wr_wdc && !reg_wr.data[`BIT_WATCHDOG_ENABLE];
	// gear and ratio code: soft code or strap widened to five bits
	wire [4:0] ratio_code = override ? soft_code : {1'b1, strap_now};
	wire [31:0] step_cyc  = scale_reg ? STEP_LONG_CYC : STEP_SHORT_CYC;
	wire pre_tick      = (pre_count_reg == step_cyc - 32'd1);
	wire timeout       = (wd_state_reg == wd_count) && pre_tick
		&& (wd_count_reg <= 5'h01);
	wire freq_change   = sel_ok || cpu_pair_ok || rec_pair_ok;

	// ==========================================
	// frequency word selection
	freq_word_s word_next;
	always_comb begin
		word_next = '0;
		if (timeout || locked) begin
			// recovery source chosen at time-out
			if (recov_pair) begin
				word_next.prog_mode   = 1'b1;
				word_next.numerator   = recov_num_next;
				word_next.denominator = recov_den_next[6:0];
				word_next.gear_code   = ratio_code;
			end else begin
				word_next.gear_code   = {1'b1, strap_now};
			end
		end else if (prog_en) begin
			// fcpu = gear * (n+3)/(m+3) done in the synthesizer
			word_next.prog_mode   = 1'b1;
			word_next.numerator   = cpu_num_next;
			word_next.denominator = cpu_den_next[6:0];
			word_next.gear_code   = ratio_code;
		end else begin
			word_next.gear_code = override ? soft_code : {1'b1, strap_now};
		end
	end

	// ==========================================
	// strap latch, caught on first cycle after reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			strap_taken_reg <= 1'b0;
			strap_reg       <= 4'h0;
		end else if (!strap_taken_reg) begin
			strap_taken_reg <= 1'b1;
			strap_reg       <= strap_freq_code;
		end
	end

	// ==========================================
	// frequency-related registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			freq_sel_reg  <= `RST_ZERO_BYTE;
			recov_num_reg <= `RST_ZERO_BYTE;
			recov_den_reg <= `RST_ZERO_BYTE;
			cpu_num_reg   <= `RST_ZERO_BYTE;
			cpu_den_reg   <= `RST_ZERO_BYTE;
			factory_reg   <= `RST_FACTORY_TEST;
		end else begin
			if (sel_ok)
				freq_sel_reg <= reg_wr.data;
			if (wr_rnum && !locked)
				recov_num_reg <= reg_wr.data;
			if (wr_rden && !locked)
				recov_den_reg <= reg_wr.data;
			if (wr_cnum && !locked)
				cpu_num_reg <= reg_wr.data;
			if (wr_cden && !locked)
				cpu_den_reg <= reg_wr.data;
			if (wr_fact)
				factory_reg <= reg_wr.data;
		end
	end

	// ==========================================
	// watchdog control registers and sticky flag
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wd_ctrl_reg    <= `RST_ZERO_BYTE;
			to_flag_reg    <= 1'b0;
			wd_timeout_reg <= `RST_WDOG_TIMER;
			scale_reg      <= 1'b0;
		end else begin
			if (wr_wdc)
				wd_ctrl_reg <= reg_wr.data;
			// set wins over a same-cycle clear
			if (timeout)
				to_flag_reg <= 1'b1;
			else if (wr_wdc && reg_wr.data[`BIT_TO_FLAG])
				to_flag_reg <= 1'b0;
			if (wr_wdt) begin
				wd_timeout_reg <= reg_wr.data[4:0];
				scale_reg      <= reg_wr.data[`BIT_SCALE];
			end
		end
	end

	// ==========================================
	// watchdog state machine
	always_ff @(posedge clk_sys) begin
		if (rst || watchdog_enable_clear) begin
			wd_state_reg  <= wd_idle;
			wd_count_reg  <= wd_timeout_reg;
			pre_count_reg <= '0;
		end else begin
			case (wd_state_reg)
				wd_idle: begin
					if (watchdog_enable || (wr_wdc && reg_wr.data[`BIT_WATCHDOG_ENABLE]))
						wd_state_reg <= wd_armed;
					wd_count_reg  <= wd_timeout_reg;
					pre_count_reg <= '0;
				end
				wd_armed: begin
					// count starts only once the frequency moved
					wd_count_reg <= wd_timeout_reg;
					if (change_reg)
						wd_state_reg <= wd_count;
				end
				wd_count: begin
					if (pre_tick) begin
						pre_count_reg <= '0;
						wd_count_reg  <= wd_count_reg - 5'h01;
						if (wd_count_reg <= 5'h01)
							wd_state_reg <= wd_locked;
					end else begin
						pre_count_reg <= pre_count_reg + 32'd1;
					end
				end
				wd_locked: begin
					// held until software clears the enable
					wd_state_reg <= wd_locked;
				end
				default: wd_state_reg <= wd_idle;
			endcase
		end
	end

	// ==========================================
	// outputs: frequency word, load strobe, reset pulse
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			freq_word       <= '0;
			freq_load       <= 1'b0;
			change_reg      <= 1'b0;
			rst_pulse_reg   <= 8'h00;
			sys_reset_n_oe  <= 1'b0;
			recovery_active <= 1'b0;
		end else begin
			change_reg      <= freq_change || timeout;
			freq_load       <= freq_change || timeout;
			// clearing the enable unlocks at once, even in the time-out cycle
			recovery_active <= (locked || timeout) && !watchdog_enable_clear;
			if (freq_change || timeout || !strap_taken_reg)
				freq_word <= word_next;
			// reset pulse loads on time-out or after a change
			if ((timeout && wd_ctrl_reg[`BIT_RST_ON_TO])
				|| (change_reg && !timeout && wd_ctrl_reg[`BIT_RST_ON_CHG]))
				rst_pulse_reg <= `RESET_PULSE_CYC;
			else if (rst_pulse_reg != 8'h00)
				rst_pulse_reg <= rst_pulse_reg - 8'h01;
			sys_reset_n_oe <= (rst_pulse_reg != 8'h00);
		end
	end

	// ==========================================
	// read mux
	logic [7:0] rd_next;
	always_comb begin
		if (rd_addr == `OFS_FREQ_SELECT)
			rd_next = freq_sel_reg;
		else if (rd_addr == `OFS_WDOG_CTRL)
			rd_next = {wd_ctrl_reg[7:3], to_flag_reg, wd_ctrl_reg[1:0]};
		else if (rd_addr == `OFS_WDOG_TIMER)
			rd_next = {2'b00, scale_reg, wd_timeout_reg};
		else if (rd_addr == `OFS_RECOV_NUM)
			rd_next = recov_num_reg;
		else if (rd_addr == `OFS_RECOV_DEN)
			rd_next = recov_den_reg;
		else if (rd_addr == `OFS_CPU_NUM)
			rd_next = cpu_num_reg;
		else if (rd_addr == `OFS_CPU_DEN)
			rd_next = cpu_den_reg;
		else if (rd_addr == `OFS_FACTORY_TEST)
			rd_next = factory_reg;
		else
			rd_next = 8'h00;  // spare bytes and unmapped read zero
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			rd_data <= 8'h00;
		else
			rd_data <= rd_next;
	end
endmodule
`default_nettype wire

// ===== freq_ctrl_assertions.sv
// port-level checks for the frequency program and watchdog block
// assumes it is bound onto freq_ctrl; one clock, sync active-high reset
`include "freq_ctrl_cfg.svh"
`default_nettype none
module freq_ctrl_assertions
	import freq_ctrl_pkg::*;
#(
	parameter int unsigned STEP_SHORT_CYC = 4,
	parameter int unsigned STEP_LONG_CYC  = 8
) (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic [3:0] strap_freq_code,
	input wire reg_wr_s    reg_wr,
	input wire logic [6:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire freq_word_s freq_word,
	input wire logic       freq_load,
	input wire logic       sys_reset_n_oe,
	input wire logic       recovery_active
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========================================
	// shadow of the control bits, rebuilt from writes
	logic [2:0] ctl_reg;    // {on time-out, on change, enable}
	logic [2:0] settle_reg; // edges since reset, stops at 4
	wire        ctl_wr = reg_wr.we && reg_wr.addr == `OFS_WDOG_CTRL;
	wire        frq_wr = reg_wr.we && reg_wr.addr inside {`OFS_CPU_NUM, `OFS_CPU_DEN};
	// settle hides the strap update just after reset, which has no load pulse
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctl_reg    <= 3'h0;
			settle_reg <= 3'h0;
		end else begin
			if (ctl_wr) ctl_reg <= {reg_wr.data[4], reg_wr.data[3], reg_wr.data[1]};
			settle_reg <= settle_reg + 3'(settle_reg != 3'h4);
		end
	end
	// full reset pulse: sixteen high cycles then low
	sequence pulse_16;
		sys_reset_n_oe [*8] ##1 sys_reset_n_oe [*8] ##1 !sys_reset_n_oe;
	endsequence
	// pin left alone for a while
	sequence quiet_4;
		!sys_reset_n_oe [*4];
	endsequence
	// ==========================================
	// frequency loads
	chk_load_on_write: assert property (frq_wr && !recovery_active |=> freq_load)
		else $error("no load after a frequency write");
	chk_locked_quiet: assert property (frq_wr && recovery_active |=> !freq_load)
		else $error("load while locked in recovery");
	chk_word_moves: assert property (
		settle_reg == 3'h4 && $changed(freq_word) |-> freq_load)
		else $error("frequency word moved without a load");
	// ==========================================
	// watchdog and lock
	chk_unlock_clear: assert property (
		ctl_wr && !reg_wr.data[`BIT_WATCHDOG_ENABLE] |=> !recovery_active)
		else $error("still locked after enable cleared");
	chk_lock_holds: assert property (recovery_active && !ctl_wr |=> recovery_active)
		else $error("lock dropped without a control write");
	chk_idle_no_lock: assert property (
		!ctl_reg[0] && !recovery_active |=> !recovery_active)
		else $error("locked while watchdog disabled");
	// ==========================================
	// reset pin
	chk_pulse_length: assert property ($rose(sys_reset_n_oe) |-> pulse_16)
		else $error("reset pulse length wrong");
	chk_change_reset: assert property (
		frq_wr && !recovery_active && ctl_reg[1] |-> ##[2:3] sys_reset_n_oe)
		else $error("no reset pulse after a change");
	chk_timeout_reset: assert property (
		$rose(recovery_active) && ctl_reg[2] |-> ##[0:3] sys_reset_n_oe)
		else $error("no reset pulse after a time-out");
	chk_timeout_quiet: assert property (
		$rose(recovery_active) && ctl_reg[2:1] == 2'b00 && !sys_reset_n_oe |-> quiet_4)
		else $error("reset pulse on a time-out while disabled");
endmodule
bind freq_ctrl freq_ctrl_assertions #(
	.STEP_SHORT_CYC(STEP_SHORT_CYC), .STEP_LONG_CYC(STEP_LONG_CYC)
) freq_ctrl_assertions_inst (
	.clk_sys(clk_sys), .rst(rst), .strap_freq_code(strap_freq_code), .reg_wr(reg_wr),
	.rd_addr(rd_addr), .rd_data(rd_data), .freq_word(freq_word), .freq_load(freq_load),
	.sys_reset_n_oe(sys_reset_n_oe), .recovery_active(recovery_active)
);
`default_nettype wire

// ===== host_model.sv
// byte-level model of the system host that programs the block
// assumes the bench calls its tasks; after the idle values at time zero it drives only at falling edges
`include "freq_ctrl_cfg.svh"
`default_nettype none
module host_model
	import freq_ctrl_pkg::*;
(
	input  wire logic       clk_sys,
	output var  reg_wr_s    reg_wr,
	output var  logic [6:0] rd_addr,
	input  wire logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus from time zero
	initial begin
		reg_wr  = '0;
		rd_addr = 7'h7f;
	end
	// one byte write; stale fields inverted so nobody leans on them
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = '{we: 1'b1, addr: a, data: d};
		@(negedge clk_sys);
		reg_wr = '{we: 1'b0, addr: ~a, data: ~d};
	endtask
	// numerator then denominator as two writes, each of which loads, so the half-written pair is briefly in effect
	task automatic wr_pair(input logic [6:0] a, input logic [7:0] n, m);
		wr(a, n);
		wr(a + 7'h1, m);
	endtask
	// read answers one cycle after the offset
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		rd_addr = a;
		@(negedge clk_sys);
		d = rd_data;
	endtask
	// start-up write of the factory byte
	task automatic init();
		wr(`OFS_FACTORY_TEST, 8'h03);
	endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the frequency program and watchdog block
// assumes short watchdog steps of 4 and 8 cycles and a fixed strap code
`default_nettype none
module testbench
	import freq_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] strap_code = 4'h9; // strap level held from time zero
	logic       clk_sys = 1'b0;
	logic       rst     = 1'b1;
	reg_wr_s    reg_wr;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	freq_word_s freq_word;
	logic       freq_load, sys_reset_n_oe, recovery_active;
	int         mismatches   = 0;
	int         total_checks = 0;
	always #4 clk_sys = ~clk_sys;
	freq_ctrl #(.STEP_SHORT_CYC(4), .STEP_LONG_CYC(8)) freq_ctrl_inst (
		.clk_sys(clk_sys), .rst(rst), .strap_freq_code(strap_code), .reg_wr(reg_wr),
		.rd_addr(rd_addr), .rd_data(rd_data), .freq_word(freq_word), .freq_load(freq_load),
		.sys_reset_n_oe(sys_reset_n_oe), .recovery_active(recovery_active));
	host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .rd_addr(rd_addr), .rd_data(rd_data));
	// ==========================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// counts cycles with the reset pin driven over n cycles
	task automatic count_pulse(input int n, output int hits);
		hits = 0;
		repeat (n) begin
			@(negedge clk_sys);
			hits += int'(sys_reset_n_oe === 1'b1);
		end
	endtask
	// arms the watchdog, makes one change, times the lock
	task automatic lat_run(input logic [7:0] ctl, tmr, src, output int lat, hits);
		int n;
		host.wr(7'h0e, 8'h00);
		host.wr(7'h0f, tmr);
		host.wr_pair(7'h12, 8'd200, src);
		host.wr(7'h0e, ctl); // armed before the change
		count_pulse(20, n);
		check(recovery_active, 1'b0);
		host.wr(7'h14, 8'd150);
		lat = 0;
		hits = 0;
		while (recovery_active !== 1'b1 && lat < 200) begin
			@(negedge clk_sys);
			lat++;
			hits += int'(sys_reset_n_oe === 1'b1);
		end
		// a hang here would stall the run: give up and report
		if (lat == 200) begin
			mismatches++;
			finish_test();
		end
		count_pulse(20, n);
		hits += n;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		logic [6:0] a [6] = '{7'h16, 7'h0f, 7'h10, 7'h11, 7'h15, 7'h7f};
		logic [7:0] v [6] = '{8'h03, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00};
		logic [7:0] d;
		check({freq_word.gear_code, freq_word.prog_mode}, {1'b1, strap_code, 1'b0});
		foreach (a[i]) begin
			host.rd(a[i], d);
			check(d, v[i]);
		end
		host.init();
	endtask
	// every soft code, scattered over the select byte
	task automatic t_select();
		logic [4:0] c;
		for (int i = 0; i < 32; i++) begin
			c = 5'(i);
			host.wr(7'h00, {1'b0, c[2:0], 1'b1, c[4:3], 1'b0});
			host.wr(7'h15, 8'h5d);
			check(freq_load, 1'b1);
			check({freq_word.gear_code, freq_word.prog_mode}, {c, 1'b0});
		end
		host.wr(7'h00, 8'h00);
	endtask
	task automatic t_prog();
		host.wr(7'h15, 8'hdd);
		check(freq_word, {1'b1, strap_code, 8'h00, 7'h5d, 1'b1});
		host.wr(7'h14, 8'd150); // ratio above one, in range
		check(freq_load, 1'b1);
		check(freq_word.numerator, 8'd150);
		host.wr(7'h00, 8'h5c);
		host.wr_pair(7'h14, 8'd150, 8'hdd);
		check(freq_word, {5'h15, 8'd150, 7'h5d, 1'b1});
		host.wr(7'h00, 8'h00);
	endtask
	task automatic t_change();
		int hits;
		host.wr(7'h0e, 8'h08);
		host.wr(7'h14, 8'd160);
		count_pulse(24, hits);
		check(hits, 16);
		host.wr(7'h0e, 8'h00);
		host.wr(7'h14, 8'd170);
		count_pulse(24, hits);
		check(hits, 0);
	endtask
	task automatic t_watchdog();
		int l0, l1, hits;
		logic [7:0] d;
		lat_run(8'h12, 8'h02, 8'hdd, l0, hits);
		check(hits, 16);
		check(freq_word, {1'b1, strap_code, 8'd200, 7'h5d, 1'b1});
		host.rd(7'h0e, d);
		check(d[2], 1'b1);
		host.wr(7'h14, 8'd77);
		check({freq_load, freq_word.numerator}, {1'b0, 8'd200});
		host.wr(7'h0e, 8'h16);
		host.rd(7'h0e, d);
		check({d[2], recovery_active}, 2'b01);
		// one long step must last as long as two short ones
		lat_run(8'h02, 8'h20, 8'h5d, l1, hits);
		check(hits, 0);
		check(l1, l0);
		check({freq_word.gear_code, freq_word.prog_mode}, {1'b1, strap_code, 1'b0});
		host.wr(7'h0e, 8'h00);
		check(recovery_active, 1'b0);
		host.wr(7'h14, 8'd77);
		check(freq_load, 1'b1);
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (6) @(negedge clk_sys);
		rst = 1'b0;
		repeat (3) @(negedge clk_sys);
		t_reset();
		t_select();
		t_prog();
		t_change();
		t_watchdog();
		finish_test();
	end
endmodule
`default_nettype wire
